// File: hw/mrp_pkg.sv
// package: constants, register map and carrier types of the memory region protection unit
package mrp_pkg;
  localparam int MRP_NUM_REGIONS = 8;
  localparam int MRP_ADDR_W = 6;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_CTRL = 6'h00;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_COUNT = 6'h04;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_SELECT = 6'h08;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_BASE = 6'h0C;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_ATTR = 6'h10;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_FAULT = 6'h14;
  localparam logic [MRP_ADDR_W-1:0] MRP_OFS_FADDR = 6'h18;
  // ctrl bits
  localparam int MRP_CTRL_EN = 0;
  localparam int MRP_CTRL_FH = 1;
  localparam int MRP_CTRL_PB = 2;
  // attribute fields
  localparam int MRP_ATTR_EN = 0;
  localparam int MRP_ATTR_SIZE_LSB = 1;
  localparam int MRP_ATTR_SRD_LSB = 8;
  localparam int MRP_ATTR_AP_LSB = 24;
  localparam int MRP_ATTR_XN = 28;
  localparam logic [4:0] MRP_SIZE_MIN = 5'h04;
  localparam logic [4:0] MRP_SIZE_SRD_MIN = 5'h07;
  localparam logic [2:0] MRP_AP_NONE = 3'h0;
  localparam logic [2:0] MRP_AP_PRW = 3'h1;
  localparam logic [2:0] MRP_AP_PRW_URO = 3'h2;
  localparam logic [2:0] MRP_AP_RW = 3'h3;
  localparam logic [2:0] MRP_AP_PRO = 3'h5;
  localparam logic [2:0] MRP_AP_RO = 3'h6;
  localparam logic [31:0] MRP_RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic xn;
    logic [2:0] ap;
    logic [7:0] srd;
    logic [4:0] size;
    logic en;
    logic [31:0] base;
  } mrp_region_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic fetch;
    logic priv;
    logic inHandler;
  } mrp_access_t;

  typedef struct packed {
    logic valid;
    logic fault;
  } mrp_verdict_t;

  function automatic logic [31:0] mrp_attr_word(input mrp_region_t r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[MRP_ATTR_EN] = r.en;
    w[MRP_ATTR_SIZE_LSB +: 5] = r.size;
    w[MRP_ATTR_SRD_LSB +: 8] = r.srd;
    w[MRP_ATTR_AP_LSB +: 3] = r.ap;
    w[MRP_ATTR_XN] = r.xn;
    return w;
  endfunction
endpackage

// File: hw/mrp_region_match.sv
// one region's address and sub-region match
`timescale 1ns/1ps
module mrp_region_match (
  input mrp_pkg::mrp_region_t region, // region settings
  input logic [31:0] addr, // access address
  output logic hit // region matches address
);
  import mrp_pkg::*;
  logic [32:0] span;
  logic [32:0] mask;
  logic inRange;
  logic [2:0] subIdx;
  logic [5:0] sizeLog;
  always_comb begin
    sizeLog = {1'b0, region.size} + 6'h01; // size field n means 2^(n+1) bytes
    span = 33'h0_0000_0001 << sizeLog;
    mask = ~(span - 33'h0_0000_0001);
    inRange = (({1'b0, addr} & mask) == ({1'b0, region.base} & mask));
    subIdx = 3'(({1'b0, addr} >> (sizeLog - 6'h03)) & 33'h0_0000_0007);
    hit = region.en && (region.size >= MRP_SIZE_MIN) && inRange;
    if (region.size >= MRP_SIZE_SRD_MIN && region.srd[subIdx]) begin
      hit = 1'b0;
    end
  end
endmodule // mrp_region_match

// File: hw/mrp_perm_check.sv
// permission decision for one access against one region's settings
`timescale 1ns/1ps
module mrp_perm_check (
  input mrp_pkg::mrp_region_t region, // one region's settings
  input mrp_pkg::mrp_access_t acc, // access under test
  output logic allowed // access allowed
);
  import mrp_pkg::*;
  logic canRead;
  logic canWrite;
  always_comb begin
    canRead = 1'b0;
    canWrite = 1'b0;
    case (region.ap)
      MRP_AP_PRW: begin
        canRead = acc.priv;
        canWrite = acc.priv;
      end
      MRP_AP_PRW_URO: begin
        canRead = 1'b1;
        canWrite = acc.priv;
      end
      MRP_AP_RW: begin
        canRead = 1'b1;
        canWrite = 1'b1;
      end
      MRP_AP_PRO: canRead = acc.priv;
      MRP_AP_RO: canRead = 1'b1;
      default: begin
        canRead = 1'b0;
        canWrite = 1'b0;
      end
    endcase
    allowed = acc.write ? canWrite : canRead;
    if (acc.fetch && region.xn) begin
      allowed = 1'b0;
    end
  end
endmodule // mrp_perm_check

// File: hw/mrp_unit.sv
// top of the memory region protection unit: registers and access checking
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module mrp_unit #(
  parameter int NumRegions = mrp_pkg::MRP_NUM_REGIONS // implemented regions
) (
  input logic ref_clk, // 125 MHz clock
  input logic rst_b, // async reset, active low
  input logic [mrp_pkg::MRP_ADDR_W-1:0] regAddr, // register byte address
  input logic [31:0] regWdata, // register write data
  input logic regWr, // write strobe
  input logic regRd, // read strobe
  output logic [31:0] regRdata, // read data, cycle after strobe
  input mrp_pkg::mrp_access_t access, // core access
  output mrp_pkg::mrp_verdict_t verdict // registered verdict, cycle after access
);
  import mrp_pkg::*;

  initial begin
    if (NumRegions < 1 || NumRegions > MRP_NUM_REGIONS) begin
      $error("NumRegions must be 1..8");
    end
  end

  typedef struct packed {
    logic [NumRegions-1:0][$bits(mrp_region_t)-1:0] rgn;
    logic unitEn;
    logic protectInHandlers;
    logic privBackground;
    logic [2:0] sel;
    logic [31:0] rdata;
    mrp_verdict_t verdict;
    logic faultSticky;
    logic [31:0] faultAddr;
  } mrp_state_t;

  mrp_state_t state_q;
  mrp_state_t state_d;

  logic [NumRegions-1:0] hits;
  logic [NumRegions-1:0] allows;
  logic anyHit;
  logic winAllow;
  logic checkOn;
  logic faultNow;

  genvar g;
  generate
    for (g = 0; g < NumRegions; g++) begin : gRegion
      mrp_region_match uMatch (
        .region(mrp_region_t'(state_q.rgn[g])),
        .addr(access.addr),
        .hit(hits[g])
      );
      mrp_perm_check uPerm (
        .region(mrp_region_t'(state_q.rgn[g])),
        .acc(access),
        .allowed(allows[g])
      );
    end
  endgenerate

  always_comb begin
    anyHit = 1'b0;
    winAllow = 1'b0;
    for (int i = 0; i < NumRegions; i++) begin
      if (hits[i]) begin // later index overrides: highest region wins
        anyHit = 1'b1;
        winAllow = allows[i];
      end
    end
    // handler bypass unless the protect option is set off unit never
    checkOn = state_q.unitEn && (!access.inHandler || state_q.protectInHandlers);
    if (!anyHit) begin
      faultNow = checkOn && !(access.priv && state_q.privBackground);
    end else begin
      faultNow = checkOn && !winAllow;
    end
  end

  function automatic logic [31:0] read_word(input mrp_state_t s, input logic [MRP_ADDR_W-1:0] a);
    logic [31:0] w;
    mrp_region_t r;
    w = 32'h0000_0000;
    r = mrp_region_t'(s.rgn[s.sel]);
    case (a)
      MRP_OFS_CTRL: begin
        w[MRP_CTRL_EN] = s.unitEn;
        w[MRP_CTRL_FH] = s.protectInHandlers;
        w[MRP_CTRL_PB] = s.privBackground;
      end
      MRP_OFS_COUNT: w = 32'(NumRegions);
      MRP_OFS_SELECT: w = {29'h0000_0000, s.sel};
      MRP_OFS_BASE: w = r.base;
      MRP_OFS_ATTR: w = mrp_attr_word(r);
      MRP_OFS_FAULT: w = {31'h0000_0000, s.faultSticky};
      MRP_OFS_FADDR: w = s.faultAddr;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb begin
    mrp_region_t r;
    r = mrp_region_t'(state_q.rgn[state_q.sel]);
    state_d = state_q;
    state_d.verdict.valid = access.valid;
    state_d.verdict.fault = access.valid && faultNow;
    if (regRd) begin
      state_d.rdata = read_word(state_q, regAddr);
    end
    if (regWr) begin
      case (regAddr)
        MRP_OFS_CTRL: begin
          state_d.unitEn = regWdata[MRP_CTRL_EN];
          state_d.protectInHandlers = regWdata[MRP_CTRL_FH];
          state_d.privBackground = regWdata[MRP_CTRL_PB];
        end
        MRP_OFS_SELECT: begin
          if (regWdata < 32'(NumRegions)) begin // whole word compared so index 8 cannot alias region 0
            state_d.sel = regWdata[2:0];
          end
        end
        MRP_OFS_BASE: r.base = regWdata; // alignment left to software
        MRP_OFS_ATTR: begin
          r.en = regWdata[MRP_ATTR_EN]; // whole word written: enable alone clears other fields
          r.size = regWdata[MRP_ATTR_SIZE_LSB +: 5];
          r.srd = regWdata[MRP_ATTR_SRD_LSB +: 8];
          r.ap = regWdata[MRP_ATTR_AP_LSB +: 3];
          r.xn = regWdata[MRP_ATTR_XN];
        end
        MRP_OFS_FAULT: begin
          if (regWdata[0]) begin
            state_d.faultSticky = 1'b0;
          end
        end
        default: ;
      endcase
      state_d.rgn[state_q.sel] = r; // no shadowing: software disables first
    end
    if (access.valid && faultNow) begin // set wins over clear
      state_d.faultSticky = 1'b1;
      state_d.faultAddr = access.addr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdata = state_q.rdata;
  assign verdict = state_q.verdict;
endmodule // mrp_unit

// File: test/mrp_unit_chk.sv
// checker: port-level assertions of the protection unit
`timescale 1ns/1ps
module mrp_unit_chk #(
  parameter int NumRegions = 8 // implemented regions
) (
  input logic ref_clk, // clock
  input logic rst_b, // reset
  input logic [mrp_pkg::MRP_ADDR_W-1:0] regAddr, // address
  input logic [31:0] regWdata, // write data
  input logic regWr, // write strobe
  input logic regRd, // read strobe
  input logic [31:0] regRdata, // read data
  input mrp_pkg::mrp_access_t access, // core access
  input mrp_pkg::mrp_verdict_t verdict // verdict
);
  import mrp_pkg::*;
  logic [2:0] ctrlQ;
  logic [2:0] selQ;
  logic [31:0] attrQ [8];
  // shadow of the control, select and attribute registers, attributes masked to implemented fields
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlQ <= '0;
      selQ <= '0;
      attrQ <= '{default: '0};
    end else if (regWr) begin
      if (regAddr == MRP_OFS_CTRL) ctrlQ <= regWdata[2:0];
      if (regAddr == MRP_OFS_SELECT && regWdata < NumRegions) selQ <= regWdata[2:0];
      if (regAddr == MRP_OFS_ATTR) attrQ[selQ] <= regWdata & 32'h1700_FF3F;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_verdict_follows: assert property (##1 verdict.valid == $past(access.valid))
    else $error("verdict valid not one cycle after access");
  a_off_no_fault: assert property (access.valid && !ctrlQ[MRP_CTRL_EN] |=> !verdict.fault)
    else $error("fault while unit disabled");
  a_handler_bypass: assert property (access.valid && access.inHandler && !ctrlQ[MRP_CTRL_FH] |=> !verdict.fault)
    else $error("fault inside handler without protect option");
  a_count_read: assert property (regRd && regAddr == MRP_OFS_COUNT |=> regRdata == NumRegions)
    else $error("region count wrong");
  a_select_kept: assert property (regRd && regAddr == MRP_OFS_SELECT |=> regRdata == {29'h0, $past(selQ)})
    else $error("region select wrong");
  a_attr_readback: assert property (regRd && regAddr == MRP_OFS_ATTR |=> (regRdata & 32'h1700_FF3F) == attrQ[$past(selQ)])
    else $error("attribute readback differs");
  a_unmapped_zero: assert property (regRd && regAddr >= 6'h1C |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!regRd |=> $stable(regRdata))
    else $error("read data changed without read");
endmodule // mrp_unit_chk
bind mrp_unit mrp_unit_chk #(.NumRegions(NumRegions)) i_mrp_unit_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .access(access), .verdict(verdict));

// File: test/mrp_core_model.sv
// core model: issues one access at a time to the unit
`timescale 1ns/1ps
module mrp_core_model (
  input logic ref_clk, // clock
  output mrp_pkg::mrp_access_t access // access to unit
);
  import mrp_pkg::*;
  initial access = '0;
  // kind is write, fetch, priv, inHandler; idle lines show inverted values
  task automatic issue(input logic [31:0] a, input logic [3:0] kind);
    @(posedge ref_clk);
    access <= {1'b1, a, kind};
    @(posedge ref_clk);
    access <= {1'b0, ~a, ~kind};
  endtask
endmodule // mrp_core_model

// File: test/mrp_unit_tb.sv
// testbench: register and access scenarios of the protection unit
`timescale 1ns/1ps
module mrp_unit_tb;
  import mrp_pkg::*;
  localparam logic [7:0] PrOk = 8'h6E;
  localparam logic [7:0] PwOk = 8'h0E;
  localparam logic [7:0] UrOk = 8'h4C;
  localparam logic [7:0] UwOk = 8'h08;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [MRP_ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  mrp_access_t access;
  mrp_verdict_t verdict;
  int mismatches = 0;
  int comparisons = 0;
  always #4 ref_clk = ~ref_clk;
  mrp_unit #(.NumRegions(8)) i_mrp_unit (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .access(access), .verdict(verdict));
  mrp_core_model i_mrp_core_model (.ref_clk(ref_clk), .access(access));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [MRP_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [MRP_ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 check("read data", exp, regRdata);
  endtask
  task automatic acc(input logic [31:0] a, input logic [3:0] kind, input logic f);
    i_mrp_core_model.issue(a, kind);
    #1 check("verdict", {30'h0, 1'b1, f}, {30'h0, verdict});
  endtask
  // disable first so no access sees half-written settings
  task automatic region(input logic [31:0] idx, input logic [31:0] base, input logic [31:0] attr);
    wr(MRP_OFS_SELECT, idx);
    wr(MRP_OFS_ATTR, 32'h0);
    wr(MRP_OFS_BASE, base);
    wr(MRP_OFS_ATTR, attr);
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(MRP_OFS_COUNT, 32'h8);
    rd(6'h1C, 32'h0);
    acc(32'h0, 4'h8, 1'b0);
    wr(MRP_OFS_CTRL, 32'h1);
    acc(32'h0, 4'h2, 1'b1);
    wr(MRP_OFS_CTRL, 32'h5);
    acc(32'h0, 4'h2, 1'b0);
    acc(32'h0, 4'h0, 1'b1);
    region(0, 32'h0, 32'h0600_801D);
    rd(MRP_OFS_BASE, 32'h0);
    rd(MRP_OFS_ATTR, 32'h0600_801D);
    acc(32'h100, 4'h0, 1'b0);
    acc(32'h100, 4'h8, 1'b1);
    acc(32'h100, 4'h4, 1'b0);
    acc(32'h7000, 4'h0, 1'b1);
    acc(32'h8000, 4'h0, 1'b1);
    region(1, 32'h7000, 32'h1300_0017);
    acc(32'h7000, 4'h8, 1'b0);
    acc(32'h7004, 4'h4, 1'b1);
    // below 256 bytes the disable bits must be ignored
    region(2, 32'h0, 32'h0000_FF09);
    acc(32'h10, 4'h0, 1'b1);
    acc(32'h20, 4'h0, 1'b0);
    wr(MRP_OFS_ATTR, 32'h0000_FF08);
    acc(32'h10, 4'h0, 1'b0);
    wr(MRP_OFS_ATTR, 32'h0000_FF09);
    acc(32'h10, 4'h0, 1'b1);
    acc(32'h100, 4'h9, 1'b0);
    wr(MRP_OFS_CTRL, 32'h7);
    acc(32'h100, 4'h9, 1'b1);
    for (int k = 0; k < 8; k++) begin
      region(3, 32'h1000_0000, 32'h0000_0009 | (32'(k) << 24));
      acc(32'h1000_0000, 4'h2, !PrOk[k]);
      acc(32'h1000_0000, 4'hA, !PwOk[k]);
      acc(32'h1000_0000, 4'h0, !UrOk[k]);
      acc(32'h1000_0000, 4'h8, !UwOk[k]);
    end
    rd(MRP_OFS_FAULT, 32'h1);
    rd(MRP_OFS_FADDR, 32'h1000_0000);
    wr(MRP_OFS_FAULT, 32'h1);
    rd(MRP_OFS_FAULT, 32'h0);
    wr(MRP_OFS_SELECT, 32'h8);
    rd(MRP_OFS_SELECT, 32'h3);
    wr(MRP_OFS_CTRL, 32'h0);
    acc(32'h1000_0000, 4'h8, 1'b0);
    finish_test();
  end
endmodule // mrp_unit_tb
